// >>> hdl/smbc_pkg.sv
// smbc_pkg: constants and carrier types for the supply monitor and buck control block
// assumes a 10 MHz system clock; all analog decisions arrive as comparator levels
`default_nettype none
package smbc_pkg;
	localparam int unsigned SMBC_CLK_HZ = 10000000;
	localparam int unsigned SMBC_NUM_BUCK = 3;
	// rail threshold: code 0 is 2.3 V, 0.1 V per step
	localparam int unsigned SMBC_THR_BASE_MV = 2300;
	localparam int unsigned SMBC_THR_STEP_MV = 100;
	localparam int unsigned SMBC_HYST_MV = 200;
	localparam logic [3:0] SMBC_THR_RST = 4'h7; // 3.0 V
	localparam logic SMBC_ACTION_RST = 1'b1;
	localparam logic SMBC_UNMASK_RST = 1'b0;
	localparam logic SMBC_MODE_RST = 1'b0;
	// soft-start ramp length
	localparam int unsigned SMBC_SOFTSTART_US = 400;
	localparam int unsigned SMBC_SOFTSTART_CYC = (SMBC_SOFTSTART_US * (SMBC_CLK_HZ / 1000000));
	// turn-on delay unit: code 1 is 2 ms, doubling per code
	localparam int unsigned SMBC_DELAY_UNIT_MS = 2;
	localparam int unsigned SMBC_DELAY_UNIT_CYC = (SMBC_DELAY_UNIT_MS * (SMBC_CLK_HZ / 1000));
	localparam int unsigned SMBC_VCODE_W = 6;
	localparam logic [5:0] SMBC_VCODE_RST = 6'h18; // default regulation code, arbitrary plain value

	typedef struct packed {
		logic enable_bit; // software enable bit level
		logic [2:0] delay_code; // turn-on delay select
		logic forced_pwm; // mode bit
		logic fault_irq_unmask; // fault interrupt unmask
		logic [5:0] volt_code_primary;
		logic [5:0] volt_code_alternate;
	} smbc_buck_cfg_t;

	typedef struct packed {
		logic running; // switching enabled
		logic soft_start; // ramp active
		logic [5:0] volt_code; // selected output code
		logic forced_pwm;
		logic allow_full_duty;
		logic power_good; // synced power-good
		logic fault_pending;
	} smbc_buck_stat_t;
endpackage : smbc_pkg
`default_nettype wire

// >>> hdl/smbc_buck_ctl.sv
// smbc_buck_ctl: one step-down converter's enable edge, turn-on delay and soft-start
// assumes inputs are already synchronous to sys_clk
`default_nettype none
module smbc_buck_ctl
	import smbc_pkg::*;
#(
	parameter int unsigned DELAY_UNIT_CYC = SMBC_DELAY_UNIT_CYC,
	parameter int unsigned SOFTSTART_CYC = SMBC_SOFTSTART_CYC
)
(
	input wire logic sys_clk, // system clock
	input wire logic rst_b, // async reset, active low
	input wire smbc_buck_cfg_t cfg, // configuration
	input wire logic volt_bank_pin, // synced bank select
	input wire logic force_off, // thermal or undervolt shutdown
	input wire logic pgood_sync, // synced power-good comparator
	input wire logic pgood_read, // host read of power-good bit
	output smbc_buck_stat_t stat // status
);
	typedef enum logic [1:0] {SMBC_OFF, SMBC_WAIT, SMBC_RAMP, SMBC_ON} smbc_bstate_t;
	typedef struct packed {
		smbc_bstate_t st;
		logic en_prev;
		logic [31:0] cnt;
		logic fault;
		logic [5:0] vcode;
	} smbc_bctl_t;

	smbc_bctl_t s_ff;
	smbc_bctl_t nxt_s;

	// delay length from code: 0 means none, else unit shifted by code-1
	function automatic logic [31:0] smbc_delay_cyc(input logic [2:0] code);
		logic [31:0] unit;
		unit = 32'(DELAY_UNIT_CYC);
		if (code == 3'h0)
			smbc_delay_cyc = 32'h0;
		else
			smbc_delay_cyc = unit << (code - 3'h1);
	endfunction : smbc_delay_cyc

	// next-state logic
	always_comb
	begin
		nxt_s = s_ff;
		nxt_s.en_prev = cfg.enable_bit;
		// only edges count; a steady level changes nothing
		if (cfg.enable_bit && !s_ff.en_prev && !force_off)
		begin
			nxt_s.st = SMBC_WAIT;
			nxt_s.cnt = smbc_delay_cyc(cfg.delay_code);
		end
		else if (!cfg.enable_bit && s_ff.en_prev)
			nxt_s.st = SMBC_OFF;
		else
		begin
			case (s_ff.st)
				SMBC_OFF:
					nxt_s.cnt = 32'h0;
				SMBC_WAIT:
					if (s_ff.cnt == 32'h0)
					begin
						nxt_s.st = SMBC_RAMP;
						nxt_s.cnt = 32'(SOFTSTART_CYC);
					end
					else
						nxt_s.cnt = s_ff.cnt - 32'h1;
				SMBC_RAMP:
					if (s_ff.cnt <= 32'h1)
						nxt_s.st = SMBC_ON;
					else
						nxt_s.cnt = s_ff.cnt - 32'h1;
				SMBC_ON:
					nxt_s.cnt = 32'h0;
				default:
					nxt_s.st = SMBC_OFF;
			endcase
		end
		// shutdown overrides everything, so a held-off enable needs a fresh edge
		if (force_off)
			nxt_s.st = SMBC_OFF;
		// output code follows the bank pin
		nxt_s.vcode = volt_bank_pin ? cfg.volt_code_alternate : cfg.volt_code_primary;
		// fault: set wins over clear; clears once off or good again and bit read
		if (cfg.fault_irq_unmask && s_ff.st == SMBC_ON && !pgood_sync)
			nxt_s.fault = 1'b1;
		else if (pgood_read && (pgood_sync || s_ff.st == SMBC_OFF))
			nxt_s.fault = 1'b0;
	end

	// state register
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			s_ff <= '{st: SMBC_OFF, en_prev: 1'b0, cnt: 32'h0, fault: 1'b0, vcode: SMBC_VCODE_RST};
		end
		else
			s_ff <= nxt_s;
	end

	// outputs from flops except the mode bit and power_good, taken straight from cfg and pgood_sync; full duty is never blocked by an off-time
	always_comb
	begin
		stat.running = (s_ff.st == SMBC_RAMP) || (s_ff.st == SMBC_ON);
		stat.soft_start = (s_ff.st == SMBC_RAMP);
		stat.volt_code = s_ff.vcode;
		stat.forced_pwm = cfg.forced_pwm;
		stat.allow_full_duty = 1'b1;
		stat.power_good = pgood_sync;
		stat.fault_pending = s_ff.fault;
	end
endmodule : smbc_buck_ctl
`default_nettype wire

// >>> hdl/smbc_top.sv
// smbc_top: supply monitor, thermal shutdown, low-battery pass-through, interrupt and three bucks
// assumes comparators are asynchronous levels; host bits arrive from a separate I2C slave on sys_clk
`default_nettype none
module smbc_top
	import smbc_pkg::*;
#(
	parameter int unsigned NUM_BUCK = SMBC_NUM_BUCK,
	parameter int unsigned DELAY_UNIT_CYC = SMBC_DELAY_UNIT_CYC,
	parameter int unsigned SOFTSTART_CYC = SMBC_SOFTSTART_CYC
)
(
	input wire logic sys_clk, // 10 MHz clock
	input wire logic rst_b, // async reset, active low
	input wire logic rail_below_cmp, // rail comparator, 1 while rail below threshold
	input wire logic rail_powerup_ok_cmp, // rail above threshold plus hysteresis
	input wire logic over_temp_cmp, // thermal comparator, hysteresis in analog
	input wire logic low_batt_in, // low-battery comparator result, 1 = low
	input wire logic volt_bank_pin, // bank select pin
	input wire logic [3:0] rail_threshold_sel_wdata, // host data for threshold field
	input wire logic rail_threshold_sel_we, // host write strobe for threshold
	input wire logic undervolt_action_sel, // action select from host register
	input wire logic rail_low_irq_unmask, // rail-low interrupt unmask
	input wire logic rail_low_flag_read, // pulse: host read rail-low flag
	input wire smbc_buck_cfg_t [NUM_BUCK-1:0] buck_cfg, // per-buck settings, buck_a first
	input wire logic [NUM_BUCK-1:0] pgood_cmp, // per-buck power-good comparators
	input wire logic [NUM_BUCK-1:0] pgood_read, // pulse: host read power-good bit
	output logic [3:0] rail_threshold_sel, // threshold code to the comparator DAC
	output logic rail_low_flag, // status: rail below threshold
	output logic system_enabled, // powered up and not shut down
	output logic over_temp_flag, // status: thermal shutdown active
	output smbc_buck_stat_t [NUM_BUCK-1:0] buck_stat, // per-buck control outputs
	output logic irq_out_n_o, // interrupt pin output level, always low
	output logic irq_out_n_oe, // interrupt pin enable, high while pulling low
	output logic low_batt_out_n_o, // low-battery pin output level, always low
	output logic low_batt_out_n_oe // low-battery pin enable, high while pulling low
);
	localparam int unsigned SYNC_W = 4 + NUM_BUCK;

	typedef struct packed {
		logic [SYNC_W-1:0] sync1;
		logic [SYNC_W-1:0] sync2;
		logic [3:0] thr;
		logic powered;
		logic rail_irq;
		logic irq_oe;
		logic lbo_oe;
		logic bank_sync1; // bank pin, first stage
		logic bank_sync2; // bank pin, second stage
	} smbc_top_st_t;

	smbc_top_st_t s_ff;
	smbc_top_st_t nxt_s;
	logic rail_low_s;
	logic powerup_ok_s;
	logic over_temp_s;
	logic low_batt_s;
	logic [NUM_BUCK-1:0] pgood_s;
	logic force_off;
	logic [NUM_BUCK-1:0] buck_fault;
	smbc_buck_cfg_t [NUM_BUCK-1:0] cfg_gated;

	// synchronised copies, read only from the second stage
	always_comb
	begin
		rail_low_s = s_ff.sync2[0];
		powerup_ok_s = s_ff.sync2[1];
		over_temp_s = s_ff.sync2[2];
		low_batt_s = s_ff.sync2[3];
		pgood_s = s_ff.sync2[SYNC_W-1:4];
		for (int i = 0; i < NUM_BUCK; i++)
			buck_fault[i] = buck_stat[i].fault_pending;
	end

	// shutdown sources: thermal always, undervoltage only in lockout mode
	assign force_off = over_temp_s || !s_ff.powered;

	// next-state logic
	always_comb
	begin
		nxt_s = s_ff;
		nxt_s.sync1 = {pgood_cmp, low_batt_in, over_temp_cmp, rail_powerup_ok_cmp, rail_below_cmp};
		nxt_s.sync2 = s_ff.sync1;
		// bank pin is a board level, so it passes two flops as well
		nxt_s.bank_sync1 = volt_bank_pin;
		nxt_s.bank_sync2 = s_ff.bank_sync1;
		// threshold code, 2.3 V plus 0.1 V per step, decoded by the analog DAC
		if (rail_threshold_sel_we)
			nxt_s.thr = rail_threshold_sel_wdata;
		// powering up waits for the hysteresis comparator, not just the falling one
		if (!s_ff.powered && powerup_ok_s && !rail_low_s)
			nxt_s.powered = 1'b1;
		else if (s_ff.powered && rail_low_s && !undervolt_action_sel)
			nxt_s.powered = 1'b0;
		// rail alarm: set wins over clear; clear needs rail back above rising level and a read
		if (s_ff.powered && undervolt_action_sel && rail_low_irq_unmask && rail_low_s)
			nxt_s.rail_irq = 1'b1;
		else if (rail_low_flag_read && powerup_ok_s && !rail_low_s)
			nxt_s.rail_irq = 1'b0;
		nxt_s.irq_oe = nxt_s.rail_irq || (|buck_fault);
		nxt_s.lbo_oe = low_batt_s;
	end

	// state register
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			s_ff.sync1 <= '0;
			s_ff.sync2 <= '0;
			s_ff.thr <= SMBC_THR_RST;
			s_ff.powered <= 1'b0;
			s_ff.rail_irq <= 1'b0;
			s_ff.irq_oe <= 1'b0;
			s_ff.lbo_oe <= 1'b0;
			s_ff.bank_sync1 <= 1'b0;
			s_ff.bank_sync2 <= 1'b0;
		end
		else
			s_ff <= nxt_s;
	end

	// voltage codes only reach the bucks once powered is set, even during thermal shutdown; until then defaults
	generate
		for (genvar g = 0; g < NUM_BUCK; g++)
		begin : g_buck
			always_comb
			begin
				cfg_gated[g] = buck_cfg[g];
				if (!s_ff.powered)
				begin
					cfg_gated[g].volt_code_primary = SMBC_VCODE_RST;
					cfg_gated[g].volt_code_alternate = SMBC_VCODE_RST;
				end
			end

			smbc_buck_ctl #(
				.DELAY_UNIT_CYC(DELAY_UNIT_CYC),
				.SOFTSTART_CYC(SOFTSTART_CYC)
			) u_buck (
				.sys_clk(sys_clk),
				.rst_b(rst_b),
				.cfg(cfg_gated[g]),
				.volt_bank_pin(s_ff.bank_sync2),
				.force_off(force_off),
				.pgood_sync(pgood_s[g]),
				.pgood_read(pgood_read[g]),
				.stat(buck_stat[g])
			);
		end
	endgenerate

	// outputs
	assign rail_threshold_sel = s_ff.thr;
	assign rail_low_flag = rail_low_s;
	assign system_enabled = s_ff.powered && !over_temp_s;
	assign over_temp_flag = over_temp_s;
	assign irq_out_n_o = 1'b0;
	assign irq_out_n_oe = s_ff.irq_oe;
	assign low_batt_out_n_o = 1'b0;
	assign low_batt_out_n_oe = s_ff.lbo_oe;
endmodule : smbc_top
`default_nettype wire

// >>> verif/smbc_monitor.sv
// smbc_monitor: port-level checks for smbc_top
// assumes it is bound to smbc_top and clocked by its sys_clk
`default_nettype none
module smbc_monitor
	import smbc_pkg::*;
#(
	parameter int unsigned NUM_BUCK = 3
)
(
	input wire logic sys_clk, // clock
	input wire logic rst_b, // reset
	input wire logic rail_below_cmp, // rail cmp
	input wire logic low_batt_in, // batt cmp
	input wire logic volt_bank_pin, // bank pin
	input wire logic undervolt_action_sel, // action
	input wire logic rail_low_irq_unmask, // unmask
	input wire smbc_buck_cfg_t [NUM_BUCK-1:0] buck_cfg, // cfg
	input wire logic [3:0] rail_threshold_sel, // thr
	input wire logic rail_low_flag, // flag
	input wire logic system_enabled, // enabled
	input wire logic over_temp_flag, // hot
	input wire smbc_buck_stat_t [NUM_BUCK-1:0] buck_stat, // stat
	input wire logic irq_out_n_oe, // irq pin
	input wire logic low_batt_out_n_oe // batt pin
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking dc @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);
	// stable windows cover the two sync flops plus the output register
	AST_THR_RST: assert property ($rose(rst_b) |-> rail_threshold_sel == SMBC_THR_RST)
		else $error("thr reset");
	AST_FLAG: assert property ($stable(rail_below_cmp)[*4] |-> rail_low_flag == rail_below_cmp)
		else $error("flag");
	AST_LBO: assert property ($stable(low_batt_in)[*4] |-> low_batt_out_n_oe == low_batt_in)
		else $error("batt pin");
	AST_OT: assert property (over_temp_flag[*2] |-> !(buck_stat[0].running || buck_stat[1].running || buck_stat[2].running))
		else $error("hot");
	AST_PWM: assert property (buck_stat[0].forced_pwm == buck_cfg[0].forced_pwm && buck_stat[0].allow_full_duty)
		else $error("mode");
	AST_BANK: assert property ((system_enabled && volt_bank_pin && $stable(buck_cfg[0]))[*4] |->
		buck_stat[0].volt_code == buck_cfg[0].volt_code_alternate) else $error("bank");
	AST_MASK: assert property ((!rail_low_irq_unmask && !buck_cfg[0].fault_irq_unmask && !buck_cfg[1].fault_irq_unmask &&
		!buck_cfg[2].fault_irq_unmask)[*2] |-> !irq_out_n_oe)
		else $error("mask");
	AST_UV: assert property ((!undervolt_action_sel && rail_below_cmp)[*4] |-> !system_enabled)
		else $error("uv");
	AST_RAMP: assert property ($rose(buck_stat[0].running) |-> buck_stat[0].soft_start)
		else $error("ramp");
	// main scenarios
	cover property ($rose(irq_out_n_oe));
	cover property ($rose(buck_stat[0].running));
	cover property ($fell(system_enabled));
endmodule : smbc_monitor
bind smbc_top smbc_monitor #(.NUM_BUCK(NUM_BUCK)) mon (.sys_clk, .rst_b, .rail_below_cmp, .low_batt_in,
	.volt_bank_pin, .undervolt_action_sel, .rail_low_irq_unmask, .buck_cfg, .rail_threshold_sel, .rail_low_flag,
	.system_enabled, .over_temp_flag, .buck_stat, .irq_out_n_oe, .low_batt_out_n_oe);
`default_nettype wire

// >>> verif/smbc_host_model.sv
// smbc_host_model: processor side of the two open-drain pins
// assumes board pull-ups on both wires
`default_nettype none
module smbc_host_model (
	input wire logic irq_out_n_o, // level
	input wire logic irq_out_n_oe, // enable
	input wire logic low_batt_out_n_o, // level
	input wire logic low_batt_out_n_oe, // enable
	output logic irq_line, // wire
	output logic lbo_line // wire
);
	timeunit 1ns;
	timeprecision 1ns;
	// a released pin goes to the pull-up, never holds its last level
	assign irq_line = irq_out_n_oe ? irq_out_n_o : 1'h1;
	assign lbo_line = low_batt_out_n_oe ? low_batt_out_n_o : 1'h1;
endmodule : smbc_host_model
`default_nettype wire

// >>> verif/smbc_top_tb_top.sv
// smbc_top_tb_top: directed bench for smbc_top
// assumes smbc_pkg, the host model and the bound checker are compiled first
`default_nettype none
module smbc_top_tb_top;
	import smbc_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic [3:0] thr;
		logic bank;
		logic lb;
		logic pwm;
		logic [5:0] code;
	} smbc_row_t;
	smbc_row_t rows [16];
	logic sys_clk, rst_b, rail_below_cmp, rail_powerup_ok_cmp, over_temp_cmp, low_batt_in, volt_bank_pin;
	logic [3:0] rail_threshold_sel_wdata, rail_threshold_sel;
	logic rail_threshold_sel_we, undervolt_action_sel, rail_low_irq_unmask, rail_low_flag_read;
	smbc_buck_cfg_t [2:0] buck_cfg;
	smbc_buck_stat_t [2:0] buck_stat;
	logic [2:0] pgood_cmp, pgood_read;
	logic rail_low_flag, system_enabled, over_temp_flag, irq_out_n_o, irq_out_n_oe;
	logic low_batt_out_n_o, low_batt_out_n_oe, irq_line, lbo_line;
	int mismatches, n_compared;
	// short counts keep the run small
	smbc_top #(.DELAY_UNIT_CYC(10), .SOFTSTART_CYC(8)) dut (.sys_clk, .rst_b, .rail_below_cmp, .rail_powerup_ok_cmp,
		.over_temp_cmp, .low_batt_in, .volt_bank_pin, .rail_threshold_sel_wdata, .rail_threshold_sel_we,
		.undervolt_action_sel, .rail_low_irq_unmask, .rail_low_flag_read, .buck_cfg, .pgood_cmp, .pgood_read,
		.rail_threshold_sel, .rail_low_flag, .system_enabled, .over_temp_flag, .buck_stat, .irq_out_n_o,
		.irq_out_n_oe, .low_batt_out_n_o, .low_batt_out_n_oe);
	smbc_host_model host (.irq_out_n_o, .irq_out_n_oe, .low_batt_out_n_o, .low_batt_out_n_oe, .irq_line, .lbo_line);
	// 10 MHz clock
	initial
	begin
		sys_clk = 1'h0;
		forever #50 sys_clk = ~sys_clk;
	end
	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : cyc
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic close_out;
		if (mismatches == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : close_out
	task automatic read_flag;
		rail_low_flag_read = 1'h1;
		cyc(1);
		rail_low_flag_read = 1'h0;
		cyc(3);
	endtask : read_flag
	// watchdog: tests need about 233 cycles, the 4000-cycle limit is about seventeen times that
	initial
	begin
		#400000;
		mismatches++;
		close_out();
	end
	// main sequence, inputs change on the falling edge
	initial
	begin
		{rst_b, rail_below_cmp, rail_powerup_ok_cmp, over_temp_cmp, low_batt_in, volt_bank_pin} = '0;
		{rail_threshold_sel_wdata, rail_threshold_sel_we, rail_low_irq_unmask, rail_low_flag_read} = '0;
		undervolt_action_sel = 1'h1;
		pgood_cmp = 3'h7;
		pgood_read = 3'h0;
		buck_cfg = '0;
		buck_cfg[1].enable_bit = 1'h1; // static level, no edge ever
		buck_cfg[0].delay_code = 3'h1;
		buck_cfg[0].volt_code_primary = 6'h0a;
		buck_cfg[0].volt_code_alternate = 6'h35;
		mismatches = 0;
		n_compared = 0;
		cyc(8);
		rst_b = 1'h1;
		cyc(1);
		chk(rail_threshold_sel, 4'h7);
		chk(irq_line, 1'h1);
		cyc(6);
		chk(system_enabled, 1'h0);
		chk(buck_stat[0].volt_code, SMBC_VCODE_RST);
		rail_powerup_ok_cmp = 1'h1;
		cyc(6);
		chk(system_enabled, 1'h1);
		// table: threshold code, bank pin, battery comparator, mode bit
		foreach (rows[i])
		begin
			rows[i] = '{i[3:0], i[0], i[1], i[2], i[0] ? 6'h35 : 6'h0a};
			rail_threshold_sel_wdata = rows[i].thr;
			rail_threshold_sel_we = 1'h1;
			volt_bank_pin = rows[i].bank;
			low_batt_in = rows[i].lb;
			buck_cfg[0].forced_pwm = rows[i].pwm;
			cyc(1);
			rail_threshold_sel_we = 1'h0;
			cyc(5);
			chk(rail_threshold_sel, rows[i].thr);
			chk(buck_stat[0].volt_code, rows[i].code);
			chk(lbo_line, !rows[i].lb);
			chk(buck_stat[0].forced_pwm, rows[i].pwm);
		end
		// enable edge with one delay unit, then the soft-start ramp
		buck_cfg[0].enable_bit = 1'h1;
		cyc(9);
		chk(buck_stat[0].running, 1'h0);
		cyc(4);
		chk({buck_stat[0].running, buck_stat[0].soft_start}, 2'h3);
		cyc(10);
		chk({buck_stat[0].running, buck_stat[0].soft_start}, 2'h2);
		chk(buck_stat[1].running, 1'h0);
		buck_cfg[0].enable_bit = 1'h0;
		cyc(3);
		chk(buck_stat[0].running, 1'h0);
		buck_cfg[0].delay_code = 3'h0;
		buck_cfg[0].enable_bit = 1'h1;
		cyc(3);
		chk({buck_stat[0].running, buck_stat[0].soft_start}, 2'h3);
		// overheating cuts the buck and refuses an edge meanwhile
		over_temp_cmp = 1'h1;
		cyc(4);
		chk({over_temp_flag, buck_stat[0].running}, 2'h2);
		buck_cfg[0].enable_bit = 1'h0;
		cyc(2);
		buck_cfg[0].enable_bit = 1'h1;
		cyc(2);
		over_temp_cmp = 1'h0;
		cyc(20);
		chk(buck_stat[0].running, 1'h0);
		// lockout action
		undervolt_action_sel = 1'h0;
		rail_below_cmp = 1'h1;
		cyc(5);
		chk(system_enabled, 1'h0);
		rail_below_cmp = 1'h0;
		undervolt_action_sel = 1'h1;
		cyc(8);
		// alarm action: held through an early read until rail is back and read
		rail_low_irq_unmask = 1'h1;
		rail_below_cmp = 1'h1;
		rail_powerup_ok_cmp = 1'h0;
		cyc(5);
		chk({rail_low_flag, irq_line}, 2'h2);
		read_flag();
		chk(irq_line, 1'h0);
		rail_below_cmp = 1'h0;
		rail_powerup_ok_cmp = 1'h1;
		cyc(5);
		chk({rail_low_flag, irq_line}, 2'h0);
		read_flag();
		chk(irq_line, 1'h1);
		// buck fault: held through a read while low, released once good and read
		buck_cfg[0].fault_irq_unmask = 1'h1;
		buck_cfg[0].enable_bit = 1'h0;
		cyc(2);
		buck_cfg[0].enable_bit = 1'h1;
		cyc(12);
		chk({buck_stat[0].running, buck_stat[0].soft_start, irq_line}, 3'h5);
		pgood_cmp[0] = 1'h0;
		cyc(5);
		chk({buck_stat[0].power_good, buck_stat[0].fault_pending, irq_line}, 3'h2);
		pgood_read[0] = 1'h1;
		cyc(1);
		pgood_read[0] = 1'h0;
		pgood_cmp[0] = 1'h1;
		cyc(4);
		chk({buck_stat[0].power_good, irq_line}, 2'h2);
		pgood_read[0] = 1'h1;
		cyc(1);
		pgood_read[0] = 1'h0;
		cyc(3);
		chk({buck_stat[0].fault_pending, irq_line}, 2'h1);
		close_out();
	end
endmodule : smbc_top_tb_top
`default_nettype wire
